// ### verilog/rx_out_channel.sv
// one receive channel: clock recovery, data retiming and loss detection
// assumes line pulse inputs already pass two flip-flops in the parent
`timescale 1ns/1ps
module rx_out_channel
    import rx_out_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic pos_s,
    input wire logic neg_s,
    input wire logic rx_active,
    input wire logic high_z,
    input wire logic master_tick,
    input wire logic edge_sel,
    output logic rx_clock,
    output logic rx_positive_data,
    output logic rx_negative_data,
    output logic rx_loss_indicator
);
    // ----------------------------------------
    // clock recovery
    // ----------------------------------------
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic mark_q, mark_d;
    logic mark, present, realign, hold_hi, rise_ev, fall_ev, upd_ev;
    logic rclk_q, rclk_d;

    assign mark = rx_active && !high_z && (pos_s || neg_s);
    assign present = rx_active && !high_z && !rx_loss_indicator;
    assign rise_ev = (cnt_q == CNT_LAST);
    assign fall_ev = (cnt_q == CNT_HALF - 5'h01);
    assign realign = present && mark && !mark_q;
    // a realign, or a master tick with no signal present, keeps the clock high, so no fall update then
    assign hold_hi = realign || (!present && master_tick);
    assign upd_ev = edge_sel ? (fall_ev && !hold_hi) : rise_ev;

    always_comb
    begin
        mark_d = mark;
        rclk_d = rclk_q;
        if (realign)
        begin
            cnt_d = CNT_ALIGN;
            rclk_d = 1'b1;
        end
        else if (!present && master_tick)
        begin
            cnt_d = CNT_RESET;
            rclk_d = 1'b1;
        end
        else if (rise_ev)
        begin
            cnt_d = CNT_RESET;
            rclk_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + 5'h01;
            if (fall_ev)
                rclk_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q <= CNT_RESET;
            mark_q <= 1'b0;
            rclk_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            mark_q <= mark_d;
            rclk_q <= rclk_d;
        end
    end

    assign rx_clock = rclk_q;

    // ----------------------------------------
    // data retiming
    // ----------------------------------------
    logic acc_p_q, acc_p_d, acc_n_q, acc_n_d;
    logic out_p_q, out_p_d, out_n_q, out_n_d;

    always_comb
    begin
        acc_p_d = acc_p_q || (mark && pos_s);
        acc_n_d = acc_n_q || (mark && neg_s);
        out_p_d = out_p_q;
        out_n_d = out_n_q;
        if (upd_ev)
        begin
            // muted while the receivers are off
            out_p_d = acc_p_d && rx_active;
            out_n_d = acc_n_d && rx_active;
            acc_p_d = 1'b0;
            acc_n_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_p_q <= 1'b0;
            acc_n_q <= 1'b0;
            out_p_q <= 1'b0;
            out_n_q <= 1'b0;
        end
        else
        begin
            acc_p_q <= acc_p_d;
            acc_n_q <= acc_n_d;
            out_p_q <= out_p_d;
            out_n_q <= out_n_d;
        end
    end

    assign rx_positive_data = out_p_q;
    assign rx_negative_data = out_n_q;

    // ----------------------------------------
    // loss of signal
    // ----------------------------------------
    logic [ZERO_W-1:0] zeros_q, zeros_d;
    logic loss_q, loss_d, held_q, held_d, bit_mark_q, bit_mark_d;

    always_comb
    begin
        zeros_d = zeros_q;
        loss_d = loss_q;
        held_d = held_q;
        bit_mark_d = bit_mark_q || mark;
        if (!rx_active || high_z)
        begin
            loss_d = 1'b1;
            held_d = 1'b0;
            zeros_d = ZERO_RESET;
            bit_mark_d = 1'b0;
        end
        else if (rise_ev)
        begin
            bit_mark_d = 1'b0;
            if (loss_q)
                held_d = 1'b1;
            if (bit_mark_q || mark)
            begin
                zeros_d = ZERO_RESET;
                // clears only after a full receive clock cycle high
                if (held_q)
                begin
                    loss_d = 1'b0;
                    held_d = 1'b0;
                end
            end
            else if (zeros_q != ZERO_LIMIT)
                zeros_d = zeros_q + 6'h01;
            else
                loss_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            zeros_q <= ZERO_RESET;
            loss_q <= LOSS_RESET;
            held_q <= 1'b0;
            bit_mark_q <= 1'b0;
        end
        else
        begin
            zeros_q <= zeros_d;
            loss_q <= loss_d;
            held_q <= held_d;
            bit_mark_q <= bit_mark_d;
        end
    end

    assign rx_loss_indicator = loss_q;
endmodule

// ### verilog/rx_out_pkg.sv
// constants shared by the receive status and clock output block
// assumes a single 40 MHz clk and line pulses already sliced to logic levels
// ----------------------------------------
// How it works
// ----------------------------------------
package rx_out_pkg;
    localparam int NUM_CH = 8;
    localparam int CLK_KHZ = 40000;
    localparam int LINE_RATE_KHZ = 2048;
    // truncated whole divider; the residual error is left to the realignment
    localparam int BIT_CYCLES = CLK_KHZ / LINE_RATE_KHZ;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(HALF_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ALIGN = 5'h01;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam int LOS_BITS = 32;
    localparam int ZERO_W = 6;
    localparam logic [ZERO_W-1:0] ZERO_LIMIT = ZERO_W'(LOS_BITS);
    localparam logic [ZERO_W-1:0] ZERO_RESET = 6'h00;
    localparam logic LOSS_RESET = 1'b1;
endpackage

// ### verilog/rx_out_top.sv
// eight-channel receive status and clock outputs
// assumes pins arrive asynchronous to clk; host_rx_enable comes from clk logic
`timescale 1ns/1ps
module rx_out_top
    import rx_out_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hardware_mode,
    input wire logic receivers_on_input,
    input wire logic rx_clock_edge_select,
    input wire logic [rx_out_pkg::NUM_CH-1:0] host_rx_enable,
    input wire logic [rx_out_pkg::NUM_CH-1:0] line_high_z,
    input wire logic [rx_out_pkg::NUM_CH-1:0] line_input_positive,
    input wire logic [rx_out_pkg::NUM_CH-1:0] line_input_negative,
    output logic [rx_out_pkg::NUM_CH-1:0] rx_clock,
    output logic [rx_out_pkg::NUM_CH-1:0] rx_positive_data,
    output logic [rx_out_pkg::NUM_CH-1:0] rx_negative_data,
    output logic [rx_out_pkg::NUM_CH-1:0] rx_loss_indicator
);
    import rx_out_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    localparam int SW = 3 * NUM_CH + 3;
    logic [SW-1:0] raw, s1_q, s2_q;
    assign raw = {hardware_mode, receivers_on_input, rx_clock_edge_select,
                  line_high_z, line_input_positive, line_input_negative};

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    logic hw_s, on_s, edge_s;
    logic [NUM_CH-1:0] hz_s, pos_s, neg_s, active;
    assign {hw_s, on_s, edge_s, hz_s, pos_s, neg_s} = s2_q;
    // one pin gates all channels in hardware mode; host enables otherwise
    assign active = hw_s ? {NUM_CH{on_s}} : host_rx_enable;

    // ----------------------------------------
    // master clock reference
    // ----------------------------------------
    logic [CNT_W-1:0] div_q, div_d;
    logic master_tick;
    assign master_tick = (div_q == CNT_LAST);

    always_comb
    begin
        div_d = master_tick ? CNT_RESET : div_q + 5'h01;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            div_q <= CNT_RESET;
        else
            div_q <= div_d;
    end

    // ----------------------------------------
    // channels
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            rx_out_channel u_ch (
                .clk(clk),
                .rstn(rstn),
                .pos_s(pos_s[ch]),
                .neg_s(neg_s[ch]),
                .rx_active(active[ch]),
                .high_z(hz_s[ch]),
                .master_tick(master_tick),
                .edge_sel(edge_s),
                .rx_clock(rx_clock[ch]),
                .rx_positive_data(rx_positive_data[ch]),
                .rx_negative_data(rx_negative_data[ch]),
                .rx_loss_indicator(rx_loss_indicator[ch])
            );
        end
    endgenerate
endmodule

// ### testbench/rx_out_chk.sv
// assertions on the receive output pins
// assumes binding into rx_out_top
`timescale 1ns/1ps
// ----------------
// checker
// ----------------
module rx_out_chk
    import rx_out_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hardware_mode,
    input wire logic receivers_on_input,
    input wire logic rx_clock_edge_select,
    input wire logic [rx_out_pkg::NUM_CH-1:0] line_high_z,
    input wire logic [rx_out_pkg::NUM_CH-1:0] rx_clock,
    input wire logic [rx_out_pkg::NUM_CH-1:0] rx_positive_data,
    input wire logic [rx_out_pkg::NUM_CH-1:0] rx_loss_indicator
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_on;
        (hardware_mode && !receivers_on_input)[*4] |-> &rx_loss_indicator;
    endproperty
    property p_hz;
        line_high_z[0][*4] |-> rx_loss_indicator[0];
    endproperty
    property p_rise;
        $rose(rx_clock[0]) |-> ##[1:20] $fell(rx_clock[0]);
    endproperty
    property p_fall;
        $fell(rx_clock[0]) |-> ##[1:20] $rose(rx_clock[0]);
    endproperty
    property p_clr;
        $fell(rx_loss_indicator[0]) |-> rx_clock[0];
    endproperty
    property p_hold;
        $fell(rx_loss_indicator[0]) |-> $past(rx_loss_indicator[0], 19);
    endproperty
    // edge select goes through a sync, so skip a few cycles after a change
    property p_edge(i);
        $changed(rx_positive_data[i]) && !rx_loss_indicator[i] && !$past(rx_loss_indicator[i])
            && rx_clock_edge_select == $past(rx_clock_edge_select, 4)
            |-> (rx_clock_edge_select ? $fell(rx_clock[i]) : $rose(rx_clock[i]));
    endproperty
    a_on: assert property (p_on) else $error("receivers stay on");
    a_hz: assert property (p_hz) else $error("no loss on high-z");
    a_rise: assert property (p_rise) else $error("clock stuck high");
    a_fall: assert property (p_fall) else $error("clock stuck low");
    a_clr: assert property (p_clr) else $error("loss off clock");
    a_hold: assert property (p_hold) else $error("loss too short");
    a_edge0: assert property (p_edge(0)) else $error("data edge ch0");
    a_edge7: assert property (p_edge(7)) else $error("data edge ch7");
    c_loss: cover property ($rose(rx_loss_indicator[0]));
    c_clear: cover property ($fell(rx_loss_indicator[0]));
    c_fall: cover property (rx_clock_edge_select && $changed(rx_positive_data[0]));
endmodule

// ### testbench/rx_out_far.sv
// line source and framer-side sampler
// assumes the 40 MHz bench clock
`timescale 1ns/1ps
// ----------------
// far side model
// ----------------
module rx_out_far
    import rx_out_pkg::*;
(
    input wire logic clk,
    input wire logic live,
    input wire logic edge_sel,
    input wire logic [rx_out_pkg::NUM_CH-1:0] rx_clock,
    input wire logic [rx_out_pkg::NUM_CH-1:0] rx_positive_data,
    input wire logic [rx_out_pkg::NUM_CH-1:0] rx_negative_data,
    input wire logic [rx_out_pkg::NUM_CH-1:0] rx_loss_indicator,
    output logic [rx_out_pkg::NUM_CH-1:0] pos,
    output logic [rx_out_pkg::NUM_CH-1:0] neg,
    output int marks,
    output int neg_marks,
    output logic switch_over
);
    int cnt = 0;
    int n_pos = 0;
    int n_neg = 0;
    logic side = 1'b0;
    logic ck_q = 1'b0;
    assign marks = n_pos;
    assign neg_marks = n_neg;
    // alternate marks, one per bit; silent line means no marks
    assign pos = {NUM_CH{live && !side && cnt < 9}};
    assign neg = {NUM_CH{live && side && cnt < 9}};
    assign switch_over = rx_loss_indicator[0];
    always @(posedge clk)
    begin
        cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
        if (cnt == BIT_CYCLES - 1)
            side <= !side;
        ck_q <= rx_clock[0];
        // sample on the edge opposite the update edge
        if (rx_clock[0] != ck_q && rx_clock[0] == edge_sel && rx_positive_data[0] === 1'b1)
            n_pos <= n_pos + 1;
        if (rx_clock[0] != ck_q && rx_clock[0] == edge_sel && rx_negative_data[0] === 1'b1)
            n_neg <= n_neg + 1;
    end
endmodule

// ### testbench/test_rx_out_top.sv
// bench for the receive status and clock outputs
// assumes rx_out_far as the line and framer side
`timescale 1ns/1ps
// ----------------
// bench
// ----------------
module test_rx_out_top;
    import rx_out_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hardware_mode = 1'b1;
    logic receivers_on_input = 1'b1;
    logic rx_clock_edge_select = 1'b0;
    logic [NUM_CH-1:0] host_rx_enable = 8'hff;
    logic [NUM_CH-1:0] line_high_z = 8'h00;
    logic live = 1'b0;
    logic [NUM_CH-1:0] line_input_positive, line_input_negative;
    logic [NUM_CH-1:0] rx_clock, rx_positive_data, rx_negative_data, rx_loss_indicator;
    logic switch_over;
    int marks, m0, neg_marks, n0, n_mismatch = 0, tests_run = 0, cyc = 0;
    always #12.5 clk = !clk;
    rx_out_top rx_out_top_i (.clk, .rstn, .hardware_mode, .receivers_on_input,
        .rx_clock_edge_select, .host_rx_enable, .line_high_z, .line_input_positive,
        .line_input_negative, .rx_clock, .rx_positive_data, .rx_negative_data,
        .rx_loss_indicator);
    rx_out_far rx_out_far_i (.clk, .live, .edge_sel(rx_clock_edge_select), .rx_clock,
        .rx_positive_data, .rx_negative_data, .rx_loss_indicator, .pos(line_input_positive),
        .neg(line_input_negative), .marks, .neg_marks, .switch_over);
    task automatic results;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [NUM_CH-1:0] got, input logic [NUM_CH-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bits(input int n);
        repeat (n * BIT_CYCLES) @(posedge clk);
        #2;
    endtask
    task automatic t_lock;
        live = 1'b1;
        bits(6);
        chk(rx_loss_indicator, 8'h00);
        chk({7'h00, marks > 1}, 8'h01);
        chk({7'h00, neg_marks > 1}, 8'h01);
        m0 = marks;
        n0 = neg_marks;
        rx_clock_edge_select = 1'b1;
        bits(6);
        chk({7'h00, marks > m0 + 1}, 8'h01);
        chk({7'h00, neg_marks > n0 + 1}, 8'h01);
    endtask
    task automatic t_loss;
        live = 1'b0;
        bits(30);
        chk(rx_loss_indicator, 8'h00);
        bits(6);
        chk(rx_loss_indicator, 8'hff);
        chk({7'h00, switch_over}, 8'h01);
        live = 1'b1;
        bits(6);
        chk(rx_loss_indicator, 8'h00);
    endtask
    task automatic t_off;
        receivers_on_input = 1'b0;
        bits(2);
        chk(rx_loss_indicator, 8'hff);
        chk(rx_positive_data | rx_negative_data, 8'h00);
        hardware_mode = 1'b0;
        host_rx_enable = 8'hfe;
        bits(6);
        chk(rx_loss_indicator, 8'h01);
        host_rx_enable = 8'hff;
        hardware_mode = 1'b1;
        receivers_on_input = 1'b1;
        line_high_z = 8'h01;
        bits(2);
        chk(rx_loss_indicator, 8'h01);
        line_high_z = 8'h00;
        bits(6);
        chk(rx_loss_indicator, 8'h00);
    endtask
    // one hang guard for the whole run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #2;
        chk(rx_loss_indicator, 8'hff);
        chk(rx_clock, 8'h00);
        rstn = 1'b1;
        t_lock();
        t_loss();
        t_off();
        results();
    end
endmodule
bind rx_out_top rx_out_chk rx_out_chk_i (.clk, .rstn, .hardware_mode, .receivers_on_input,
    .rx_clock_edge_select, .line_high_z, .rx_clock, .rx_positive_data, .rx_loss_indicator);
